//--- logic/rdbc_pkg.sv
package rdbc_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] RDBC_ADDR_TAIL = 8'h80;
  localparam logic [7:0] RDBC_ADDR_REV = 8'h82;
  localparam int RDBC_AW = 8;
  localparam int RDBC_DW = 32;

  // ==========================================================
  // Reverse-drive word field positions
  // ==========================================================
  localparam int RDBC_PARITY_POS = 31;
  localparam int RDBC_A1_LSB = 27;
  localparam int RDBC_A2_LSB = 23;
  localparam int RDBC_BRK_ILIM_LSB = 20;
  localparam int RDBC_KP_LSB = 10;
  localparam int RDBC_KI_LSB = 0;

  // ==========================================================
  // Preceding word tail field positions
  // ==========================================================
  localparam int RDBC_HANDOFF_LSB = 2;
  localparam int RDBC_OL_ILIM_LSB = 0;
  localparam int RDBC_TAIL_W = 6;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [31:0] RDBC_REV_RESET = 32'h0000_0000;
  localparam logic [5:0] RDBC_TAIL_RESET = 6'h00;
  localparam logic [31:0] RDBC_RD_ZERO = 32'h0000_0000;

  // Gain scaling: effective gain = stored / 2**shift
  localparam int RDBC_KP_SHIFT = 7;
  localparam int RDBC_KI_SHIFT = 9;

  // ==========================================================
  // Field carriers, laid out bit for bit as the words
  // ==========================================================
  typedef struct packed {
    logic parity;
    logic [3:0] reversal_accel_linear_coeff;
    logic [3:0] reversal_accel_square_coeff;
    logic [2:0] braking_bus_current_limit;
    logic [9:0] braking_loop_prop_gain;
    logic [9:0] braking_loop_integral_gain;
  } rdbc_rev_cfg_s;

  typedef struct packed {
    logic [3:0] reversal_handoff_speed_threshold;
    logic [1:0] reversal_open_loop_current_limit;
  } rdbc_tail_cfg_s;

endpackage : rdbc_pkg

//--- logic/rdbc_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - Bits 5..2 of preceding word pick reversal open-loop handoff speed.
// - Bits 1..0 of preceding word pick open-loop current limit in reversal.
// - Reverse-drive word lives at 82h and resets to all zeros.
// - Bits 30..27 hold linear open-loop acceleration coefficient, reverse drive.
// - Bits 26..23 hold square open-loop acceleration coefficient, reverse drive.
// - Bits 22..20 hold bus current limit while actively braking.
// - Bits 19..10 hold braking proportional gain, stored value over 128.
// - Bits 9..0 hold braking integral gain, stored value over 512.
module rdbc_regs (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rd_valid,
  output logic o_addr_err,
  output rdbc_pkg::rdbc_rev_cfg_s o_rev_cfg,
  output rdbc_pkg::rdbc_tail_cfg_s o_tail_cfg
);

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction : hit

  logic wr_rev;
  logic wr_tail;
  logic rd_rev;
  logic rd_tail;
  logic acc_bad;

  // Strobe qualification per word
  assign wr_rev = i_wr_en && hit(i_addr, rdbc_pkg::RDBC_ADDR_REV);
  assign wr_tail = i_wr_en && hit(i_addr, rdbc_pkg::RDBC_ADDR_TAIL);
  assign rd_rev = i_rd_en && hit(i_addr, rdbc_pkg::RDBC_ADDR_REV);
  assign rd_tail = i_rd_en && hit(i_addr, rdbc_pkg::RDBC_ADDR_TAIL);
  assign acc_bad = (i_wr_en || i_rd_en) &&
                   !hit(i_addr, rdbc_pkg::RDBC_ADDR_REV) &&
                   !hit(i_addr, rdbc_pkg::RDBC_ADDR_TAIL);

  // ==========================================================
  // Storage
  // ==========================================================
  rdbc_pkg::rdbc_rev_cfg_s rev_q;
  rdbc_pkg::rdbc_tail_cfg_s tail_q;

  // Whole word stored as written; the struct splits the fields
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rev_q <= rdbc_pkg::RDBC_REV_RESET;
    end else if (wr_rev) begin
      rev_q <= i_wdata;
    end
  end

  // Only the low tail of the preceding word lives here
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tail_q <= rdbc_pkg::RDBC_TAIL_RESET;
    end else if (wr_tail) begin
      tail_q <= i_wdata[rdbc_pkg::RDBC_TAIL_W-1:0];
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // Registered read: a read alongside a write returns the old value,
  // so the host never sees a half-updated word.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= rdbc_pkg::RDBC_RD_ZERO;
    end else if (rd_rev) begin
      o_rdata <= rev_q;
    end else if (rd_tail) begin
      o_rdata <= {26'h000_0000, tail_q};
    end else if (i_rd_en) begin
      o_rdata <= rdbc_pkg::RDBC_RD_ZERO;
    end
  end

  // Read strobe echo and unmapped flag, one cycle each
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_valid <= 1'b0;
      o_addr_err <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      o_addr_err <= acc_bad;
    end
  end

  // Field outputs straight from the storage flops
  assign o_rev_cfg = rev_q;
  assign o_tail_cfg = tail_q;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_rev_reset;
    @(posedge i_clk) i_srst |=> (o_rev_cfg == 32'h0000_0000);
  endproperty
  a_rev_reset: assert property (p_rev_reset)
    else $error("reverse word not zero after reset");

  property p_rev_write;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_addr == 8'h82) |=> (o_rev_cfg == $past(i_wdata));
  endproperty
  a_rev_write: assert property (p_rev_write)
    else $error("reverse word write not stored");

  property p_rev_fields;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_addr == 8'h82) |=>
        (o_rev_cfg.reversal_accel_linear_coeff == $past(i_wdata[30:27]))
        && (o_rev_cfg.reversal_accel_square_coeff == $past(i_wdata[26:23]))
        && (o_rev_cfg.braking_bus_current_limit == $past(i_wdata[22:20]));
  endproperty
  a_rev_fields: assert property (p_rev_fields)
    else $error("acceleration or brake limit field misplaced");

  property p_gain_fields;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_addr == 8'h82) |=>
        (o_rev_cfg.braking_loop_prop_gain == $past(i_wdata[19:10]))
        && (o_rev_cfg.braking_loop_integral_gain == $past(i_wdata[9:0]));
  endproperty
  a_gain_fields: assert property (p_gain_fields)
    else $error("braking gain field misplaced");

  property p_rev_hold;
    @(posedge i_clk) disable iff (i_srst)
      !(i_wr_en && i_addr == 8'h82) |=> $stable(o_rev_cfg);
  endproperty
  a_rev_hold: assert property (p_rev_hold)
    else $error("reverse word changed without a write");

  property p_tail_write;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_addr == 8'h80) |=>
        (o_tail_cfg.reversal_handoff_speed_threshold == $past(i_wdata[5:2]))
        && (o_tail_cfg.reversal_open_loop_current_limit
            == $past(i_wdata[1:0]));
  endproperty
  a_tail_write: assert property (p_tail_write)
    else $error("tail fields not stored");

  property p_tail_hold;
    @(posedge i_clk) disable iff (i_srst)
      !(i_wr_en && i_addr == 8'h80) |=> $stable(o_tail_cfg);
  endproperty
  a_tail_hold: assert property (p_tail_hold)
    else $error("tail fields changed without a write");

  property p_wr_then_rd;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_addr == 8'h82) ##1 (i_rd_en && i_addr == 8'h82)
        |=> o_rd_valid && (o_rdata == $past(i_wdata, 2));
  endproperty
  a_wr_then_rd: assert property (p_wr_then_rd)
    else $error("reverse word readback mismatch");

  property p_rd_tail;
    @(posedge i_clk) disable iff (i_srst)
      (i_rd_en && i_addr == 8'h80) |=>
        (o_rdata[31:6] == 26'h000_0000) && (o_rdata[5:0] == $past(tail_q));
  endproperty
  a_rd_tail: assert property (p_rd_tail)
    else $error("tail readback wrong");

  property p_unmapped;
    @(posedge i_clk) disable iff (i_srst)
      (i_rd_en && i_addr != 8'h80 && i_addr != 8'h82) |=>
        o_addr_err && (o_rdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not flagged as zero");

  // Read strobe echo: host relies on exactly one valid per strobe
  property p_rd_valid;
    @(posedge i_clk) disable iff (i_srst)
      i_rd_en |=> o_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read strobe not echoed as valid");

  property p_no_rd_valid;
    @(posedge i_clk) disable iff (i_srst)
      !i_rd_en |=> !o_rd_valid;
  endproperty
  a_no_rd_valid: assert property (p_no_rd_valid)
    else $error("read valid without a read strobe");

  // Read data must not drift between reads
  property p_rdata_hold;
    @(posedge i_clk) disable iff (i_srst)
      !i_rd_en |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  // Mapped words never raise the unmapped flag
  property p_mapped_ok;
    @(posedge i_clk) disable iff (i_srst)
      ((i_addr == rdbc_pkg::RDBC_ADDR_REV) ||
       (i_addr == rdbc_pkg::RDBC_ADDR_TAIL)) |=> !o_addr_err;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access flagged as unmapped");

  // Collision of read and write hands back the word before the write
  property p_rd_old;
    @(posedge i_clk) disable iff (i_srst)
      (i_wr_en && i_rd_en && i_addr == rdbc_pkg::RDBC_ADDR_REV) |=>
        (o_rdata == $past(rev_q));
  endproperty
  a_rd_old: assert property (p_rd_old)
    else $error("collided read did not return old word");

  property p_tail_reset;
    @(posedge i_clk) i_srst |=> (o_tail_cfg == rdbc_pkg::RDBC_TAIL_RESET);
  endproperty
  a_tail_reset: assert property (p_tail_reset)
    else $error("tail fields not cleared by reset");

  c_rev_write: cover property (@(posedge i_clk) disable iff (i_srst)
    i_wr_en && i_addr == 8'h82 && i_wdata[31]);
  c_wr_rd: cover property (@(posedge i_clk) disable iff (i_srst)
    (i_wr_en && i_addr == 8'h82) ##1 (i_rd_en && i_addr == 8'h82));
  c_tail_rd: cover property (@(posedge i_clk) disable iff (i_srst)
    i_rd_en && i_addr == 8'h80 && tail_q != 6'h00);
  c_bad: cover property (@(posedge i_clk) disable iff (i_srst) acc_bad);

endmodule : rdbc_regs

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // Stimulus, observation and bookkeeping
  // ==========================================================
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata;
  logic o_rd_valid;
  logic o_addr_err;
  rdbc_pkg::rdbc_rev_cfg_s o_rev_cfg;
  rdbc_pkg::rdbc_tail_cfg_s o_tail_cfg;
  logic [31:0] exp_q[$];
  logic [31:0] d;
  logic [31:0] shadow;
  int n_fail = 0;
  int n_tests = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  rdbc_regs rdbc_regs_inst (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid),
    .o_addr_err(o_addr_err),
    .o_rev_cfg(o_rev_cfg),
    .o_tail_cfg(o_tail_cfg)
  );

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One host cycle; inputs change 1 ns after the edge, never twice
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [31:0] wd, input logic [31:0] e);
    @(posedge i_clk);
    #1;
    i_wr_en = w;
    i_rd_en = r;
    i_addr = a;
    i_wdata = wd;
    if (r) begin
      exp_q.push_back(e);
    end
  endtask : op

  task automatic end_of_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // Read monitor: negedge sampling keeps clear of the launch edge
  always @(negedge i_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spurious read valid", 32'h1, 32'h0);
      end else begin
        chk("read data", o_rdata, exp_q.pop_front());
      end
    end
  end

  // Whole run is under three hundred cycles; this is far beyond it
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    void'($urandom(90));
    repeat (3) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    chk("rev reset", o_rev_cfg, 32'h0000_0000);
    op(1'b0, 1'b1, rdbc_pkg::RDBC_ADDR_REV, 32'h0, 32'h0000_0000);
    // Every code of each narrow field, random wide fields around them
    for (int k = 0; k < 64; k++) begin
      d = $urandom;
      d[30:27] = k[3:0];
      d[26:23] = 4'hf - k[3:0];
      d[22:20] = k[2:0];
      op(1'b1, 1'b0, rdbc_pkg::RDBC_ADDR_REV, d, 32'h0);
      // Upper junk must be dropped; same-cycle read sees the old tail
      op(1'b1, 1'b1, rdbc_pkg::RDBC_ADDR_TAIL, {d[31:6], k[5:0]},
         (k == 0) ? 32'h0 : 32'(k - 1));
      op(1'b0, 1'b1, rdbc_pkg::RDBC_ADDR_TAIL, 32'h0, k);
      chk("accel lin", o_rev_cfg.reversal_accel_linear_coeff, d[30:27]);
      chk("accel sq", o_rev_cfg.reversal_accel_square_coeff, d[26:23]);
      chk("brk ilim", o_rev_cfg.braking_bus_current_limit, d[22:20]);
      chk("kp", o_rev_cfg.braking_loop_prop_gain, d[19:10]);
      chk("ki", o_rev_cfg.braking_loop_integral_gain, d[9:0]);
      chk("parity", o_rev_cfg.parity, d[31]);
      op(1'b0, 1'b1, rdbc_pkg::RDBC_ADDR_REV, 32'h0, d);
      chk("handoff", o_tail_cfg.reversal_handoff_speed_threshold,
          k[5:2]);
      chk("ol ilim", o_tail_cfg.reversal_open_loop_current_limit,
          k[1:0]);
    end
    // Same-cycle read and write returns the old word
    shadow = d;
    d = ~shadow;
    op(1'b1, 1'b1, rdbc_pkg::RDBC_ADDR_REV, d, shadow);
    op(1'b0, 1'b1, rdbc_pkg::RDBC_ADDR_REV, 32'h0, d);
    // Unmapped place: flagged, write dropped, reads zero
    op(1'b1, 1'b1, 8'h81, $urandom, 32'h0000_0000);
    op(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    chk("addr err", o_addr_err, 32'h1);
    chk("tail kept", o_tail_cfg, 32'h0000_003f);
    chk("rev kept", o_rev_cfg, d);
    // Reset in mid-run clears both words
    op(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    i_srst = 1'b1;
    @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    chk("rev re-reset", o_rev_cfg, 32'h0000_0000);
    chk("tail re-reset", o_tail_cfg, 32'h0000_0000);
    op(1'b0, 1'b1, rdbc_pkg::RDBC_ADDR_REV, 32'h0, 32'h0000_0000);
    op(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    repeat (3) @(posedge i_clk);
    chk("reads pending", exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule : tb_top
